// *** core/cel_pkg.sv ***
// Shared constants and types for the core error logging and injection block.
package cel_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_STRANDS = 8;
    localparam int NUM_SOURCES = 13;

    // ----------------------------------------------------------------
    // Device register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_INJECT  = 8'h00;
    localparam logic [7:0] OFF_DEFER   = 8'h08;
    localparam logic [7:0] OFF_SUMMARY = 8'h20;
    localparam logic [7:0] OFF_FIRST   = 8'h28;

    // ----------------------------------------------------------------
    // Deferred store error register fields
    // ----------------------------------------------------------------
    localparam int DF_ADDR_PAR = 61;
    localparam int DF_DATA_IO  = 60;
    localparam int DF_PRIV_LO  = 58;
    localparam int DF_IDX_LO   = 55;

    // ----------------------------------------------------------------
    // Summary and first-error fields
    // ----------------------------------------------------------------
    localparam int SUM_LSB = 48;

    // ----------------------------------------------------------------
    // Injection register fields
    // ----------------------------------------------------------------
    localparam int INJ_ENABLE_BIT = 31;
    localparam int INJ_SRC_LO     = 17;
    localparam logic [12:0] INJ_SRC_WRITABLE = 13'h1ffd;
    localparam logic [12:0] INJ_SRC_ECC      = 13'h01f1;
    localparam logic [63:0] INJ_RESET        = 64'h0;
    localparam logic [63:0] DEFER_RESET      = 64'h0;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CEL_ERR_NONE    = 2'b00,
        CEL_ERR_CORR    = 2'b01,
        CEL_ERR_UNCORR  = 2'b10,
        CEL_ERR_NOTDATA = 2'b11
    } cel_err_t;

    typedef enum logic [1:0] {
        CEL_PRIV_USER    = 2'b00,
        CEL_PRIV_SUPER   = 2'b01,
        CEL_PRIV_HYPER   = 2'b10,
        CEL_PRIV_CORRUPT = 2'b11
    } cel_priv_t;

    // ----------------------------------------------------------------
    // Packet source register map
    // ----------------------------------------------------------------
    localparam logic [31:0] SRC_OFF_CMD    = 32'h0000_0000;
    localparam logic [31:0] SRC_OFF_STATUS = 32'h0000_0004;
    localparam int CMD_ERR_LO    = 0;
    localparam int CMD_STRAND_LO = 2;
    localparam int CMD_ASYNC     = 8;
    localparam int CMD_DMA_PF    = 9;

endpackage

// *** core/cel_if.sv ***
// Packet link between the error source and the core error logging block.
`timescale 1ns/1ps
interface cel_if;
    logic                     pkt_valid;
    logic                     pkt_async;
    cel_pkg::cel_err_t        pkt_err;
    logic [2:0]               pkt_strand;
    logic                     pkt_dma_pf;

    modport dev
    (
        input pkt_valid,
        input pkt_async,
        input pkt_err,
        input pkt_strand,
        input pkt_dma_pf
    );

    modport src
    (
        output pkt_valid,
        output pkt_async,
        output pkt_err,
        output pkt_strand,
        output pkt_dma_pf
    );
endinterface

// *** core/cel_error_src.sv ***
// Error packet source end, commanded by software over AHB-Lite.
`timescale 1ns/1ps
module cel_error_src
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    cel_if.src               link
);

    // ----------------------------------------------------------------
    // Address phase capture
    // ----------------------------------------------------------------
    logic        dp_write;
    logic        dp_read;
    logic [31:0] dp_addr;
    logic [15:0] sent_count;

    wire addr_phase = hsel_i & htrans_i[1] & hready_i;
    wire wr_cmd     = dp_write & (dp_addr == cel_pkg::SRC_OFF_CMD);
    wire rd_status  = addr_phase & ~hwrite_i
                    & (haddr_i == cel_pkg::SRC_OFF_STATUS);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 32'h0;
        end
        else
        begin
            dp_write <= addr_phase & hwrite_i;
            dp_read  <= addr_phase & ~hwrite_i;
            dp_addr  <= addr_phase ? haddr_i : dp_addr;
        end
    end

    // ----------------------------------------------------------------
    // Read data and packet launch
    // ----------------------------------------------------------------
    // Zero wait states; unmapped reads return zero and writes are dropped.
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            hrdata_o        <= 32'h0;
            hreadyout_o     <= 1'b1;
            hresp_o         <= 1'b0;
            sent_count      <= 16'h0;
            link.pkt_valid  <= 1'b0;
            link.pkt_async  <= 1'b0;
            link.pkt_err    <= cel_pkg::CEL_ERR_NONE;
            link.pkt_strand <= 3'h0;
            link.pkt_dma_pf <= 1'b0;
        end
        else
        begin
            hrdata_o        <= rd_status ? {16'h0, sent_count} : 32'h0;
            link.pkt_valid  <= wr_cmd;
            sent_count      <= sent_count + {15'h0, wr_cmd};
            if (wr_cmd)
            begin
                link.pkt_err    <= cel_pkg::cel_err_t'(
                                   hwdata_i[cel_pkg::CMD_ERR_LO +: 2]);
                link.pkt_strand <= hwdata_i[cel_pkg::CMD_STRAND_LO +: 3];
                link.pkt_async  <= hwdata_i[cel_pkg::CMD_ASYNC];
                link.pkt_dma_pf <= hwdata_i[cel_pkg::CMD_DMA_PF];
            end
        end
    end

endmodule

// *** core/cel_core_log.sv ***
// Core error logging, first-error capture, fault injection and packet traps.
`timescale 1ns/1ps

// Notes on behaviour
// - Strand deferred register clears on every read
// - Deferred register survives warm reset
// - Bit 61 address parity, bit 60 data
// - Bits 59:58 hold first failing store privilege
// - Bits 57:55 hold failing store index
// - Handler reads deferred register before storing
// - Summary holds eight 2-bit strand fields
// - Field is full flag and type OR
// - First-error mirrors summary, set from zero
// - Simultaneous strand errors all set first-error
// - First-error holds, clears when summary zero
// - Injection needs enable and a source
// - Source bits select the target arrays
// - ECC targets XOR mask into check bits
// - Software selects one source at most
// - Injection excludes first-level cache arrays
// - Injection write acts before later instructions
// - Error codes 01, 10 and 11
// - Load return traps: precise or recoverable
// - Async packet traps recoverable or corrected
// - Full flag set on valid, read clears; here the flag is taken as is from desr_full_i
module cel_core_log
#(
    parameter int NUM_STRANDS = cel_pkg::NUM_STRANDS
)
(
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     por_n_i,
    input  wire logic                     reg_rd_i,
    input  wire logic                     reg_wr_i,
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [2:0]               reg_strand_i,
    input  wire logic [63:0]              reg_wdata_i,
    output logic      [63:0]              reg_rdata_o,
    output logic                          reg_rvalid_o,
    input  wire logic [NUM_STRANDS-1:0]   sb_err_i,
    input  wire logic [NUM_STRANDS-1:0]   sb_addr_par_i,
    input  wire logic [NUM_STRANDS-1:0]   sb_data_io_i,
    input  wire logic [2*NUM_STRANDS-1:0] sb_priv_i,
    input  wire logic [3*NUM_STRANDS-1:0] sb_index_i,
    input  wire logic [NUM_STRANDS-1:0]   desr_full_i,
    output logic      [12:0]              inj_src_o,
    output logic      [7:0]               inj_ecc_mask_o,
    input  wire logic [12:0]              ecc_target_i,
    input  wire logic [7:0]               ecc_check_i,
    output logic      [7:0]               ecc_check_o,
    cel_if.dev                            link,
    output logic                          precise_trap_o,
    output logic                          sw_recov_trap_o,
    output logic                          hw_corr_trap_o,
    output logic      [2:0]               trap_strand_o
);

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire sel_inject  = reg_addr_i == cel_pkg::OFF_INJECT;
    wire sel_defer   = reg_addr_i == cel_pkg::OFF_DEFER;
    wire sel_summary = reg_addr_i == cel_pkg::OFF_SUMMARY;
    wire sel_first   = reg_addr_i == cel_pkg::OFF_FIRST;
    wire wr_inject   = reg_wr_i & sel_inject;
    wire rd_defer    = reg_rd_i & sel_defer;

    // ----------------------------------------------------------------
    // Per-strand deferred store error registers
    // ----------------------------------------------------------------
    // Each strand keeps type, privilege and index; bit 63:62 and 54:0
    // are reserved and read as zero.
    logic [1:0]             df_type  [NUM_STRANDS];
    logic [1:0]             df_priv  [NUM_STRANDS];
    logic [2:0]             df_index [NUM_STRANDS];
    logic [2*NUM_STRANDS-1:0] next_summary;
    logic [63:0]            df_word  [NUM_STRANDS];

    localparam logic [1:0] DEFER_RESET_TYPE =
        cel_pkg::DEFER_RESET[cel_pkg::DF_ADDR_PAR -: 2];

    genvar s;
    generate
        for (s = 0; s < NUM_STRANDS; s++)
        begin : g_strand
            wire rd_this = rd_defer & (reg_strand_i == 3'(s));
            wire empty   = df_type[s] == 2'b00;
            // An error arriving with the read is kept: set wins.
            wire [1:0] next_type = (rd_this ? 2'b00 : df_type[s])
                                 | ({sb_addr_par_i[s], sb_data_io_i[s]}
                                    & {2{sb_err_i[s]}});
            wire take    = sb_err_i[s] & (empty | rd_this);

            // only the cold reset touches this state.
            always_ff @(posedge core_clk_i)
            begin
                if (!por_n_i)
                begin
                    df_type[s]  <= DEFER_RESET_TYPE;
                    df_priv[s]  <= 2'b00;
                    df_index[s] <= 3'h0;
                end
                else
                begin
                    df_type[s]  <= next_type;
                    if (take)
                    begin
                        df_priv[s]  <= sb_priv_i[2*s +: 2];
                        df_index[s] <= sb_index_i[3*s +: 3];
                    end
                    else if (rd_this)
                    begin
                        df_priv[s]  <= 2'b00;
                        df_index[s] <= 3'h0;
                    end
                end
            end

            assign df_word[s] = {2'b00,
                                 df_type[s],
                                 df_priv[s],
                                 df_index[s],
                                 55'h0};
            assign next_summary[2*s +: 2] = {desr_full_i[s], |next_type};
        end
    endgenerate

    // ----------------------------------------------------------------
    // Summary and first-error capture
    // ----------------------------------------------------------------
    logic [2*NUM_STRANDS-1:0] summary;
    logic [2*NUM_STRANDS-1:0] first_err;

    // While the summary is empty every new bit, from any number of
    // strands in the same cycle, lands in the first-error copy.
    wire [2*NUM_STRANDS-1:0] next_first =
        (next_summary == '0) ? '0 :
        (summary == '0)      ? next_summary :
                               first_err;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            summary   <= '0;
            first_err <= '0;
        end
        else
        begin
            summary   <= next_summary;
            first_err <= next_first;
        end
    end

    // ----------------------------------------------------------------
    // Fault injection control
    // ----------------------------------------------------------------
    logic        inj_enable;
    logic [12:0] inj_src;
    logic [7:0]  inj_mask;

    wire  [12:0] next_src = reg_wdata_i[cel_pkg::INJ_SRC_LO +: 13]
                          & cel_pkg::INJ_SRC_WRITABLE;
    // Only the array currently writing gets its check bits flipped, and
    // only when it is an ECC array that software selected.
    wire  [12:0] ecc_hit  = inj_src_o & cel_pkg::INJ_SRC_ECC & ecc_target_i;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            inj_enable <= cel_pkg::INJ_RESET[cel_pkg::INJ_ENABLE_BIT];
            inj_src    <= cel_pkg::INJ_RESET[cel_pkg::INJ_SRC_LO +: 13];
            inj_mask   <= cel_pkg::INJ_RESET[7:0];
        end
        else if (wr_inject)
        begin
            // a write lands here on the next edge; inj_src_o and inj_ecc_mask_o follow a cycle later.
            inj_enable <= reg_wdata_i[cel_pkg::INJ_ENABLE_BIT];
            inj_src    <= next_src;
            inj_mask   <= reg_wdata_i[7:0];
        end
    end

    wire [63:0] inj_word = {32'h0,
                            inj_enable,
                            1'b0,
                            inj_src,
                            9'h0,
                            inj_mask};

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            inj_src_o      <= 13'h0;
            inj_ecc_mask_o <= 8'h0;
            ecc_check_o    <= 8'h0;
        end
        else
        begin
            inj_src_o      <= inj_enable ? inj_src : 13'h0;
            inj_ecc_mask_o <= inj_mask;
            ecc_check_o    <= ecc_check_i ^ ((ecc_hit != 13'h0) ?
                                             inj_mask : 8'h0);
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    wire [63:0] sum_word   = {summary, 48'h0};
    wire [63:0] first_word = {first_err, 48'h0};
    wire [63:0] rd_mux     = sel_inject  ? inj_word :
                             sel_defer   ? df_word[reg_strand_i] :
                             sel_summary ? sum_word :
                             sel_first   ? first_word : 64'h0;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o  <= 64'h0;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o  <= reg_rd_i ? rd_mux : 64'h0;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // ----------------------------------------------------------------
    // Packet error classification
    // ----------------------------------------------------------------
    wire is_corr  = link.pkt_err == cel_pkg::CEL_ERR_CORR;
    wire is_unc   = link.pkt_err == cel_pkg::CEL_ERR_UNCORR;
    wire is_nd    = link.pkt_err == cel_pkg::CEL_ERR_NOTDATA;
    wire on_load  = link.pkt_valid & ~link.pkt_async;
    wire on_async = link.pkt_valid & link.pkt_async;
    // NotData on an async packet raises no disrupting trap here.
    wire next_precise = on_load & (is_unc | is_nd);
    wire next_sw      = (on_load & is_corr)
                      | (on_async & is_unc)
                      | (on_async & is_corr & link.pkt_dma_pf);
    wire next_hw      = on_async & is_corr & ~link.pkt_dma_pf;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            precise_trap_o  <= 1'b0;
            sw_recov_trap_o <= 1'b0;
            hw_corr_trap_o  <= 1'b0;
            trap_strand_o   <= 3'h0;
        end
        else
        begin
            precise_trap_o  <= next_precise;
            sw_recov_trap_o <= next_sw;
            hw_corr_trap_o  <= next_hw;
            trap_strand_o   <= link.pkt_valid ? link.pkt_strand
                                              : trap_strand_o;
        end
    end

endmodule

// *** testbench/cel_link_sva.sv ***
// Assertions on the packet link and the trap outputs that answer it.
`timescale 1ns/1ps
module cel_link_sva
(
    input wire logic              core_clk_i,
    input wire logic              rst_n_i,
    input wire logic              pkt_valid,
    input wire logic              pkt_async,
    input wire cel_pkg::cel_err_t pkt_err,
    input wire logic [2:0]        pkt_strand,
    input wire logic              pkt_dma_pf,
    input wire logic              precise_trap_o,
    input wire logic              sw_recov_trap_o,
    input wire logic              hw_corr_trap_o,
    input wire logic [2:0]        trap_strand_o
);
    wire logic load_pkt;
    wire logic async_pkt;
    wire logic any_trap;

    assign load_pkt  = pkt_valid & ~pkt_async;
    assign async_pkt = pkt_valid & pkt_async;
    assign any_trap  = precise_trap_o | sw_recov_trap_o | hw_corr_trap_o;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Trap classification
    // ----------------------------------------------------------------
    precise_load_a: assert property (load_pkt && pkt_err[1] |=>
        precise_trap_o && trap_strand_o == $past(pkt_strand))
        else $error("precise trap missing on load return");
    corr_load_a: assert property (load_pkt && pkt_err ==
        cel_pkg::CEL_ERR_CORR |=> sw_recov_trap_o && !precise_trap_o)
        else $error("recoverable trap missing on load return");
    load_nohw_a: assert property (load_pkt |=> !hw_corr_trap_o)
        else $error("corrected trap raised by load return");
    async_recov_a: assert property (async_pkt && (pkt_err ==
        cel_pkg::CEL_ERR_UNCORR || (pkt_err == cel_pkg::CEL_ERR_CORR
        && pkt_dma_pf)) |=> sw_recov_trap_o && !hw_corr_trap_o)
        else $error("recoverable trap missing on async packet");
    async_hw_a: assert property (async_pkt && !pkt_dma_pf &&
        pkt_err == cel_pkg::CEL_ERR_CORR |=> hw_corr_trap_o
        && !sw_recov_trap_o)
        else $error("corrected trap missing on async packet");
    async_noprec_a: assert property (async_pkt |=> !precise_trap_o)
        else $error("precise trap raised by async packet");
    no_code_a: assert property (pkt_valid && pkt_err ==
        cel_pkg::CEL_ERR_NONE |=> !any_trap)
        else $error("trap raised by code zero");
    idle_quiet_a: assert property (!pkt_valid |=> !any_trap)
        else $error("trap raised without packet");
    trap_single_a: assert property (any_trap |->
        $onehot0({precise_trap_o, sw_recov_trap_o, hw_corr_trap_o}))
        else $error("more than one trap kind at once");

    precise_c: cover property (precise_trap_o);
    recov_c: cover property (sw_recov_trap_o);
    corr_c: cover property (hw_corr_trap_o);
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench joining the error source and the core logging end.
`timescale 1ns/1ps
module testbench;
    logic        core_clk_i;
    logic        rst_n_i;
    logic        por_n_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        reg_rd;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [2:0]  reg_strand;
    logic [63:0] reg_wdata;
    logic [63:0] reg_rdata;
    logic        reg_rvalid;
    logic [7:0]  sb_err;
    logic [7:0]  sb_addr_par;
    logic [7:0]  sb_data_io;
    logic [15:0] sb_priv;
    logic [23:0] sb_index;
    logic [7:0]  desr_full;
    logic [12:0] inj_src;
    logic [7:0]  inj_mask;
    logic [12:0] ecc_target;
    logic [7:0]  ecc_out;
    logic        t_prec;
    logic        t_sw;
    logic        t_hw;
    logic [2:0]  t_strand;
    logic [63:0] rd;
    logic [31:0] q32;
    int          n_errors;
    int          checks_done;
    int          n_prec;
    int          n_sw;
    int          n_hw;

    cel_if link ();

    cel_error_src i_cel_error_src (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(), .link(link));

    cel_core_log i_cel_core_log (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .por_n_i(por_n_i), .reg_rd_i(reg_rd),
        .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
        .reg_strand_i(reg_strand), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
        .sb_err_i(sb_err), .sb_addr_par_i(sb_addr_par),
        .sb_data_io_i(sb_data_io), .sb_priv_i(sb_priv),
        .sb_index_i(sb_index), .desr_full_i(desr_full),
        .inj_src_o(inj_src), .inj_ecc_mask_o(inj_mask),
        .ecc_target_i(ecc_target), .ecc_check_i(8'h3c),
        .ecc_check_o(ecc_out), .link(link), .precise_trap_o(t_prec),
        .sw_recov_trap_o(t_sw), .hw_corr_trap_o(t_hw),
        .trap_strand_o(t_strand));

    cel_link_sva i_cel_link_sva (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .pkt_valid(link.pkt_valid),
        .pkt_async(link.pkt_async), .pkt_err(link.pkt_err),
        .pkt_strand(link.pkt_strand), .pkt_dma_pf(link.pkt_dma_pf),
        .precise_trap_o(t_prec), .sw_recov_trap_o(t_sw),
        .hw_corr_trap_o(t_hw), .trap_strand_o(t_strand));

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk_i);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk_i); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk_i); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic dev_rd(input logic [7:0] a, input logic [2:0] s,
                          output logic [63:0] q);
        @(posedge core_clk_i);
        reg_rd     <= 1'b1;
        reg_addr   <= a;
        reg_strand <= s;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        #1;
        q = (reg_rvalid === 1'b1) ? reg_rdata : 64'hx;
    endtask

    task automatic dev_wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge core_clk_i);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask

    // Every strand carries the same privilege and index; the pulse mask and the parity mask ap differ per strand.
    task automatic sb_log(input logic [7:0] m, input logic [7:0] ap,
                          input logic [1:0] pv, input logic [2:0] ix);
        @(posedge core_clk_i);
        sb_err      <= m;
        sb_addr_par <= ap;
        sb_data_io  <= ~ap;
        sb_priv     <= {8{pv}};
        sb_index    <= {8{ix}};
        @(posedge core_clk_i);
        sb_err <= 8'h00;
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        n_prec += (t_prec === 1'b1);
        n_sw   += (t_sw === 1'b1);
        n_hw   += (t_hw === 1'b1);
    end

    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        n_errors++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_n_i, por_n_i, hsel, hwrite, reg_rd, reg_wr} = '0;
        {haddr, hwdata, reg_wdata, sb_priv, sb_index} = '0;
        {htrans, reg_addr, reg_strand, sb_err, desr_full} = '0;
        {sb_addr_par, sb_data_io, ecc_target} = '0;
        {n_errors, checks_done, n_prec, n_sw, n_hw} = '0;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        // Every code on both packet kinds, with and without the DMA flag.
        for (int k = 0; k < 16; k++)
            ahb(1'b1, cel_pkg::SRC_OFF_CMD,
                {22'h0, k[3], k[2], 3'h0, k[2:0], k[1:0]}, q32);
        repeat (4) @(posedge core_clk_i);
        chk("precise", 64'd4, 64'(n_prec));
        chk("recoverable", 64'd5, 64'(n_sw));
        chk("corrected", 64'd1, 64'(n_hw));
        ahb(1'b0, cel_pkg::SRC_OFF_STATUS, 32'h0, q32);
        chk("sent", 64'd16, {48'h0, q32[15:0]});
        ahb(1'b0, 32'h0000_0008, 32'h0, q32);
        chk("src unmapped", 64'h0, {32'h0, q32});
        sb_log(8'h08, 8'hff, 2'h2, 3'h5);
        dev_rd(cel_pkg::OFF_SUMMARY, 3'h0, rd);
        chk("summary", 64'h1 << 54, rd);
        dev_rd(cel_pkg::OFF_FIRST, 3'h0, rd);
        chk("first", 64'h1 << 54, rd);
        sb_log(8'h20, 8'h00, 2'h3, 3'h7);
        dev_rd(cel_pkg::OFF_SUMMARY, 3'h0, rd);
        chk("summary", 64'h0440_0000_0000_0000, rd);
        dev_rd(cel_pkg::OFF_FIRST, 3'h0, rd);
        chk("first", 64'h1 << 54, rd);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        dev_rd(cel_pkg::OFF_DEFER, 3'h3, rd);
        chk("deferred", {4'h2, 2'h2, 3'h5, 55'h0}, rd);
        dev_rd(cel_pkg::OFF_DEFER, 3'h3, rd);
        chk("deferred", 64'h0, rd);
        dev_rd(cel_pkg::OFF_DEFER, 3'h5, rd);
        chk("deferred", {4'h1, 2'h3, 3'h7, 55'h0}, rd);
        repeat (2) @(posedge core_clk_i);
        dev_rd(cel_pkg::OFF_FIRST, 3'h0, rd);
        chk("first", 64'h0, rd);
        sb_log(8'h81, 8'hff, 2'h0, 3'h0);
        desr_full <= 8'h04;
        repeat (2) @(posedge core_clk_i);
        dev_rd(cel_pkg::OFF_FIRST, 3'h0, rd);
        chk("first", 64'h4001_0000_0000_0000, rd);
        dev_rd(cel_pkg::OFF_SUMMARY, 3'h0, rd);
        chk("summary", 64'h4021_0000_0000_0000, rd);
        desr_full <= 8'h00;
        dev_rd(cel_pkg::OFF_DEFER, 3'h0, rd);
        chk("deferred", 64'h2000_0000_0000_0000, rd);
        dev_rd(cel_pkg::OFF_DEFER, 3'h7, rd);
        repeat (2) @(posedge core_clk_i);
        dev_rd(cel_pkg::OFF_FIRST, 3'h0, rd);
        chk("first", 64'h0, rd);
        dev_wr(cel_pkg::OFF_INJECT, 64'hffff_ffff_c044_00a5);
        dev_rd(cel_pkg::OFF_INJECT, 3'h0, rd);
        chk("inject", 64'h0000_0000_8040_00a5, rd);
        // Each source in turn: only ECC arrays see the mask.
        for (int b = 0; b < 13; b++)
        begin
            dev_wr(cel_pkg::OFF_INJECT, 64'h8000_005a | (64'h1 << (17 + b)));
            ecc_target <= 13'h1 << b;
            repeat (2) @(posedge core_clk_i);
            #1;
            chk("source", cel_pkg::INJ_SRC_WRITABLE[b] ? 64'h1 << b : 64'h0,
                64'(inj_src));
            chk("check bits", cel_pkg::INJ_SRC_ECC[b] ? 64'h66 : 64'h3c,
                64'(ecc_out));
        end
        chk("mask", 64'h5a, 64'(inj_mask));
        dev_wr(cel_pkg::OFF_INJECT, 64'h0040_00ff);
        ecc_target <= 13'h020;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("source", 64'h0, 64'(inj_src));
        chk("check bits", 64'h3c, 64'(ecc_out));
        dev_rd(8'h10, 3'h0, rd);
        chk("unmapped", 64'h0, rd);
        conclude();
    end
endmodule
